// file: common/tcu_defines.vh
// Register map, field positions, reset values and codes of the timer unit
`ifndef TCU_DEFINES_VH
`define TCU_DEFINES_VH

// Byte addresses of the registers
`define TCU_ADDR_PIN_CTRL   8'h00
`define TCU_ADDR_RUN_HALT   8'h04
`define TCU_CH_BASE         8'h08
`define TCU_CH_STRIDE       8'h0C
`define TCU_OFS_CONST       8'h00
`define TCU_OFS_COUNT       8'h04
`define TCU_OFS_CTRL        8'h08
`define TCU_ADDR_CAPTURE    8'h2C

// Field positions of a channel control register
`define TCU_BIT_CAP_FLAG    9
`define TCU_BIT_UNF         8
`define TCU_BIT_CAP_HI      7
`define TCU_BIT_CAP_LO      6
`define TCU_BIT_UNDERFLOW_IRQ_ENABLE        5
`define TCU_EDGE_HI         4
`define TCU_EDGE_LO         3
`define TCU_SEL_HI          2
`define TCU_SEL_LO          0

// Writable configuration bits of the control registers
`define TCU_CTRL_MASK_BASIC 8'h3F
`define TCU_CTRL_MASK_CH2   8'hFF

// Reset values
`define TCU_PIN_CTRL_RST    8'h00
`define TCU_RUN_HALT_RST    8'h00
`define TCU_CTRL_RST        16'h0000
`define TCU_CONST_RST       32'hFFFFFFFF
`define TCU_COUNT_RST       32'hFFFFFFFF
`define TCU_CAPTURE_RST     32'h00000000

// Clock select codes
`define TCU_SEL_DIV4        3'h0
`define TCU_SEL_DIV16       3'h1
`define TCU_SEL_DIV64       3'h2
`define TCU_SEL_DIV256      3'h3
`define TCU_SEL_RTC         3'h4
`define TCU_SEL_EXT         3'h5

// Edge select codes
`define TCU_EDGE_RISE       2'h0
`define TCU_EDGE_FALL       2'h1

// Prescaler width and channel count
`define TCU_PRE_W           8
`define TCU_NUM_CH          3

`endif

// file: logic/tcu_prescale.v
// Free-running prescaler giving one-cycle ticks at /4, /16, /64 and /256
`timescale 1ns/1ps
`include "tcu_defines.vh"
module tcu_prescale
(
  input  wire       clock_i,   // Peripheral clock
  input  wire       rst_n_i,   // Asynchronous reset, active low
  output wire [3:0] tick_o     // Ticks: [0] /4 [1] /16 [2] /64 [3] /256
);

  reg [`TCU_PRE_W-1:0] div_r;

  // Divider count runs on every rising edge
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      div_r <= {`TCU_PRE_W{1'b0}};
    else
      div_r <= div_r + 8'h01;
  end

  // A tick stands when the low bits are all ones
  assign tick_o[0] = &div_r[1:0];
  assign tick_o[1] = &div_r[3:0];
  assign tick_o[2] = &div_r[5:0];
  assign tick_o[3] = &div_r[7:0];

endmodule // tcu_prescale

// file: logic/tcu_edge.v
// Edge detector on the timer pin with selectable edge
`timescale 1ns/1ps
`include "tcu_defines.vh"
module tcu_edge
(
  input  wire       clock_i,   // Peripheral clock
  input  wire       rst_n_i,   // Asynchronous reset, active low
  input  wire       pin_i,     // Timer pin level
  input  wire [1:0] edge_sel_i,// Edge select field
  output reg        pulse_o    // One-cycle pulse on selected edge
);

  reg  prev_r;
  wire rise;
  wire fall;

  // Previous pin level
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prev_r <= 1'b0;
    else
      prev_r <= pin_i;
  end

  assign rise = pin_i & ~prev_r;
  assign fall = ~pin_i & prev_r;

  // Choose rising, falling or both edges
  always @*
  begin
    case (edge_sel_i)
      `TCU_EDGE_RISE: pulse_o = rise;
      `TCU_EDGE_FALL: pulse_o = fall;
      default:        pulse_o = rise | fall;
    endcase
  end

endmodule // tcu_edge

// file: logic/tcu_top.v
// Three-channel down-counting timer unit with control and status registers
//
// Notes on behaviour
// - Pin select 0 input, 1 drives RTC clock
// - Upper pin and run bits read zero
// - Pin control resets zero, kept in standby
// - Run bits start or halt each channel
// - Low power clears run unless RTC source
// - Control resets zero, retained in low power
// - Control holds flag, enable, edge, clock
// - Capture fields only on channel two
// - Capture flag set on capture, cleared by 0
// - Underflow flag set on wrap, cleared by 0
// - Capture field: 00 off, 10 masked, 11 on
// - Underflow request only when enable is set
// - Edge select: rise, fall or both
// - Clock codes /16, /64, /256, RTC, pin
// - Capture copies channel two count on edge
// - Clock code 000 selects divide by four
// - Count down, reload on underflow, continue
// - Reserved control bits read zero
`timescale 1ns/1ps
`include "tcu_defines.vh"
module tcu_top
(
  input  wire        clock_i,          // Peripheral clock, 100 MHz
  input  wire        rst_n_i,          // Power-on or manual reset, low
  input  wire [7:0]  addr_i,           // Register byte address
  input  wire [31:0] wdata_i,          // Write data
  input  wire        wr_i,             // Write strobe
  input  wire        rd_i,             // Read strobe
  output reg  [31:0] rdata_o,          // Read data, cycle after strobe
  input  wire        low_power_i,      // Standby, PLL change or stop
  input  wire        rtc_clk_i,        // Real-time-clock output clock
  input  wire        timer_ext_pin_i,  // Timer pin input level
  output reg         timer_ext_pin_o,  // Timer pin output level
  output reg         timer_ext_pin_oe_n_o, // Timer pin drive, low drives
  output reg  [2:0]  underflow_irq_o,  // Underflow requests per channel
  output reg         capture_irq_o     // Capture request, channel two
);

  // Register map, one 32-bit word per register, byte addresses:
  //   0x00  pin control, bit 0 selects the pin direction
  //   0x04  run bits, bit g runs channel g
  //   0x08  channel 0 reload constant
  //   0x0C  channel 0 counter
  //   0x10  channel 0 control
  //   0x14  channel 1 reload constant
  //   0x18  channel 1 counter
  //   0x1C  channel 1 control
  //   0x20  channel 2 reload constant
  //   0x24  channel 2 counter
  //   0x28  channel 2 control, with capture fields
  //   0x2C  channel 2 capture register, read only
  // Unmapped addresses read zero and ignore writes.
  //
  // Control word layout:
  //   bit 9     capture flag, channel 2 only
  //   bit 8     underflow flag
  //   bits 7:6  capture control, channel 2 only
  //   bit 5     underflow request enable
  //   bits 4:3  pin edge select
  //   bits 2:0  count clock select
  // Only bits 7:0 are stored; the flags live in their own flops so
  // that a hardware set and a software clear can be resolved in one
  // place, with the set winning when both land in the same cycle.
  //
  // Hazards a user must know:
  //   The pin is taken as synchronous; an asynchronous source needs
  //   a synchroniser in front of this block.
  //   Clock codes 110 and 111 give no ticks, so the channel stalls.
  //   Capture code 01 is stored but neither captures nor requests.
  //   Low power clears run bits of non-RTC channels every cycle it
  //   stands, so a run write during low power is lost on purpose.
  //   Interrupt levels lag their flags by one clock, because every
  //   top-level output comes from a flip-flop.

  // Shared registers
  reg  [7:0]  pin_ctrl_r;
  reg  [7:0]  run_halt_r;
  reg  [7:0]  run_halt_nxt;
  reg         rtc_prev_r;
  reg         cap_flag_r;
  reg  [31:0] capture_r;
  reg  [31:0] rdata_nxt;

  // Per-channel results gathered from the channel loop
  wire [3:0]  pre_tick;
  wire        rtc_tick;
  wire        pin_output_select;
  wire [2:0]  stop_req;
  wire [2:0]  unf_w;
  wire [2:0]  underflow_irq_enable_w;
  wire [2:0]  edge_w;
  wire [95:0] chan_rd;
  wire [31:0] ch2_count;
  wire [7:0]  ch2_cfg;
  wire        cap_edge;
  wire        cap_enable;
  wire        cap_wr;
  wire        cap_clear;

  assign pin_output_select = pin_ctrl_r[0];
  assign rtc_tick          = rtc_clk_i & ~rtc_prev_r;

  // Shared prescaler
  tcu_prescale u_pre
  (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .tick_o  (pre_tick)
  );

  // RTC edge reference and pin drive
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rtc_prev_r           <= 1'b0;
      timer_ext_pin_o      <= 1'b0;
      timer_ext_pin_oe_n_o <= 1'b1;
    end
    else
    begin
      rtc_prev_r           <= rtc_clk_i;
      timer_ext_pin_o      <= rtc_clk_i & pin_output_select;
      timer_ext_pin_oe_n_o <= ~pin_output_select;
    end
  end

  // Pin control register, bit 0 only; kept through low power
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pin_ctrl_r <= `TCU_PIN_CTRL_RST;
    else if (wr_i && addr_i == `TCU_ADDR_PIN_CTRL)
      pin_ctrl_r <= {7'h00, wdata_i[0]};
  end

  // Run bits: a low-power stop overrides a write
  always @*
  begin
    run_halt_nxt = run_halt_r;
    if (wr_i && addr_i == `TCU_ADDR_RUN_HALT)
      run_halt_nxt = {5'h00, wdata_i[2:0]};
    run_halt_nxt[2:0] = run_halt_nxt[2:0] & ~stop_req;
  end

  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      run_halt_r <= `TCU_RUN_HALT_RST;
    else
      run_halt_r <= run_halt_nxt;
  end

  // One block per channel: counter, reload, control and flag
  genvar g;
  generate
    for (g = 0; g < `TCU_NUM_CH; g = g + 1)
    begin : g_ch
      // Base address worked out wide, then cut to the bus width
      localparam integer A_BASE_I = `TCU_CH_BASE + g * `TCU_CH_STRIDE;
      localparam [7:0] A_BASE  = A_BASE_I[7:0];
      localparam [15:0] CTRL_RST = `TCU_CTRL_RST;
      localparam [7:0] A_CONST = A_BASE + `TCU_OFS_CONST;
      localparam [7:0] A_COUNT = A_BASE + `TCU_OFS_COUNT;
      localparam [7:0] A_CTRL  = A_BASE + `TCU_OFS_CTRL;
      localparam [7:0] MASK    = (g == 2) ? `TCU_CTRL_MASK_CH2
                                          : `TCU_CTRL_MASK_BASIC;

      reg  [31:0] const_r;
      reg  [31:0] count_r;
      reg  [7:0]  cfg_r;
      reg         unf_r;
      reg         src_tick;
      wire        ext_edge;
      wire        hold;
      wire        tick;
      wire        uflow;
      wire        wr_const;
      wire        wr_count;
      wire        wr_ctrl;
      wire [15:0] ctrl_rd;

      assign wr_const = wr_i && addr_i == A_CONST;
      assign wr_count = wr_i && addr_i == A_COUNT;
      assign wr_ctrl  = wr_i && addr_i == A_CTRL;

      // Edge of the timer pin for this channel
      tcu_edge u_edge
      (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .pin_i      (timer_ext_pin_i),
        .edge_sel_i (cfg_r[`TCU_EDGE_HI:`TCU_EDGE_LO]),
        .pulse_o    (ext_edge)
      );

      // Count clock selection
      always @*
      begin
        case (cfg_r[`TCU_SEL_HI:`TCU_SEL_LO])
          `TCU_SEL_DIV4:   src_tick = pre_tick[0];
          `TCU_SEL_DIV16:  src_tick = pre_tick[1];
          `TCU_SEL_DIV64:  src_tick = pre_tick[2];
          `TCU_SEL_DIV256: src_tick = pre_tick[3];
          `TCU_SEL_RTC:    src_tick = rtc_tick;
          `TCU_SEL_EXT:    src_tick = ext_edge &
                                      ~pin_output_select;
          default:         src_tick = 1'b0;
        endcase
      end

      // Low power freezes all but the RTC source
      assign hold = low_power_i &&
                    cfg_r[`TCU_SEL_HI:`TCU_SEL_LO] != `TCU_SEL_RTC;
      assign stop_req[g] = hold;
      assign tick  = run_halt_r[g] & ~hold & src_tick;
      assign uflow = tick && count_r == 32'h00000000 && !wr_count;

      // Reload constant
      always @(posedge clock_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          const_r <= `TCU_CONST_RST;
        else if (wr_const)
          const_r <= wdata_i;
      end

      // Down counter; a write wins over a tick
      always @(posedge clock_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          count_r <= `TCU_COUNT_RST;
        else if (wr_count)
          count_r <= wdata_i;
        else if (uflow)
          count_r <= const_r;
        else if (tick)
          count_r <= count_r - 32'h00000001;
      end

      // Control fields, reserved bits never stored
      always @(posedge clock_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          cfg_r <= CTRL_RST[7:0];
        else if (wr_ctrl)
          cfg_r <= wdata_i[7:0] & MASK;
      end

      // Underflow flag: a set beats a clear by writing 0
      always @(posedge clock_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          unf_r <= 1'b0;
        else
          unf_r <= uflow |
                   (unf_r & ~(wr_ctrl & ~wdata_i[`TCU_BIT_UNF]));
      end

      assign ctrl_rd = {6'h00,
                        (g == 2) ? cap_flag_r : 1'b0,
                        unf_r, cfg_r};

      // Read data of this channel, zero when not addressed
      assign chan_rd[32*g +: 32] =
        (addr_i == A_CONST) ? const_r :
        (addr_i == A_COUNT) ? count_r :
        (addr_i == A_CTRL)  ? {16'h0000, ctrl_rd} : 32'h00000000;

      assign unf_w[g]  = unf_r;
      assign underflow_irq_enable_w[g] = cfg_r[`TCU_BIT_UNDERFLOW_IRQ_ENABLE];
      assign edge_w[g] = ext_edge;
    end
  endgenerate

  assign ch2_count  = g_ch[2].count_r;
  assign ch2_cfg    = g_ch[2].cfg_r;
  assign cap_enable = ch2_cfg[`TCU_BIT_CAP_HI];
  assign cap_edge   = edge_w[2] & cap_enable & ~pin_output_select;
  assign cap_wr     = wr_i && addr_i == `TCU_CH_BASE +
                      8'h02 * `TCU_CH_STRIDE + `TCU_OFS_CTRL;
  assign cap_clear  = cap_wr & ~wdata_i[`TCU_BIT_CAP_FLAG];

  // Capture register and flag; the set beats a clear by writing 0
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      capture_r  <= `TCU_CAPTURE_RST;
      cap_flag_r <= 1'b0;
    end
    else
    begin
      if (cap_edge)
        capture_r <= ch2_count;
      cap_flag_r <= cap_edge | (cap_flag_r & ~cap_clear);
    end
  end

  // Interrupt request levels
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      underflow_irq_o <= 3'h0;
      capture_irq_o   <= 1'b0;
    end
    else
    begin
      underflow_irq_o <= unf_w & underflow_irq_enable_w;
      capture_irq_o   <= cap_flag_r & cap_enable &
                         ch2_cfg[`TCU_BIT_CAP_LO];
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always @*
  begin
    rdata_nxt = chan_rd[31:0] | chan_rd[63:32] | chan_rd[95:64];
    case (addr_i)
      `TCU_ADDR_PIN_CTRL: rdata_nxt = {24'h000000, pin_ctrl_r};
      `TCU_ADDR_RUN_HALT: rdata_nxt = {24'h000000, run_halt_r};
      `TCU_ADDR_CAPTURE:  rdata_nxt = capture_r;
      default:            rdata_nxt = rdata_nxt;
    endcase
  end

  // Read data register, stands only the cycle after the strobe
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 32'h00000000;
    else if (rd_i)
      rdata_o <= rdata_nxt;
    else
      rdata_o <= 32'h00000000;
  end

endmodule // tcu_top

// file: tb/tcu_cpu_model.sv
// Processor bus master model for the timer unit
`timescale 1ns/1ps
module tcu_cpu_model
(
  input  wire logic        clock_i,  // Clock
  output logic      [7:0]  addr_o,   // Address
  output logic      [31:0] wdata_o,  // Write data
  output logic             wr_o,     // Write strobe
  output logic             rd_o      // Read strobe
);
  // Quiet bus at time zero
  initial
  begin
    addr_o = 8'h3C;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // One write cycle; released lines show the inverse value
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clock_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  end
  endtask

  // One read cycle; data is picked up by the bench monitor
  task automatic rd(input logic [7:0] a);
  begin
    @(posedge clock_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clock_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
  end
  endtask
endmodule // tcu_cpu_model

// file: tb/tcu_asserts.sv
// Port checker of the timer unit
`timescale 1ns/1ps
module tcu_asserts
(
  input wire logic        clock_i,              // Clock
  input wire logic        rst_n_i,              // Reset, low
  input wire logic [7:0]  addr_i,               // Address
  input wire logic [31:0] wdata_i,              // Write data
  input wire logic        wr_i,                 // Write strobe
  input wire logic        rd_i,                 // Read strobe
  input wire logic [31:0] rdata_o,              // Read data
  input wire logic        low_power_i,          // Low power
  input wire logic        rtc_clk_i,            // RTC clock
  input wire logic        timer_ext_pin_i,      // Pin in
  input wire logic        timer_ext_pin_o,      // Pin out
  input wire logic        timer_ext_pin_oe_n_o, // Pin drive, low
  input wire logic [2:0]  underflow_irq_o,      // Underflow requests
  input wire logic        capture_irq_o         // Capture request
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  // Reserved bits, pin select, irq masking
  AST_PIN_RSV: assert property ($past(rd_i) && $past(addr_i) == 8'h00
    |-> rdata_o[31:1] == 31'h0) else $error("pin control upper bits set");
  AST_RUN_RSV: assert property ($past(rd_i) && $past(addr_i) == 8'h04
    |-> rdata_o[31:3] == 29'h0) else $error("run upper bits set");
  AST_CTRL_RSV: assert property ($past(rd_i) &&
    ($past(addr_i) == 8'h10 || $past(addr_i) == 8'h1C)
    |-> rdata_o[31:9] == 23'h0 && rdata_o[7:6] == 2'h0)
    else $error("basic control reserved bits set");
  AST_CTRL2_RSV: assert property ($past(rd_i) && $past(addr_i) == 8'h28
    |-> rdata_o[31:10] == 22'h0) else $error("control two reserved bits set");
  AST_OE_DIR: assert property (wr_i && addr_i == 8'h00
    ##1 !(wr_i && addr_i == 8'h00) |-> ##1
    timer_ext_pin_oe_n_o == !$past(wdata_i[0], 2)) else $error("pin drive wrong");
  AST_PIN_IDLE: assert property (timer_ext_pin_oe_n_o |-> !timer_ext_pin_o)
    else $error("pin output not low");
  AST_PIN_RTC: assert property (!timer_ext_pin_oe_n_o
    |-> timer_ext_pin_o == $past(rtc_clk_i)) else $error("pin not rtc clock");
  AST_UNF_MASK: assert property (rd_i && addr_i == 8'h10
    ##1 (!wr_i && !rdata_o[5]) ##1 !wr_i |-> !underflow_irq_o[0])
    else $error("masked underflow request");
  AST_CAP_MASK: assert property (rd_i && addr_i == 8'h28
    ##1 (!wr_i && !rdata_o[6]) ##1 !wr_i |-> !capture_irq_o)
    else $error("masked capture request");
endmodule // tcu_asserts

bind tcu_top tcu_asserts u_chk
(
  .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .low_power_i(low_power_i),
  .rtc_clk_i(rtc_clk_i), .timer_ext_pin_i(timer_ext_pin_i),
  .timer_ext_pin_o(timer_ext_pin_o),
  .timer_ext_pin_oe_n_o(timer_ext_pin_oe_n_o),
  .underflow_irq_o(underflow_irq_o), .capture_irq_o(capture_irq_o)
);

// file: tb/testbench.sv
// Self-checking bench of the timer unit
`timescale 1ns/1ps
module testbench;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        low_power_i = 1'b0;
  logic        rtc_clk_i = 1'b0;
  logic        pin_lvl = 1'b0;
  logic        rd_seen = 1'b0;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  logic        pin_o;
  logic        oe_n;
  logic [2:0]  unf_irq;
  logic        cap_irq;
  logic [31:0] exp_q[$];
  logic [31:0] cap_exp = 32'h0;
  logic [31:0] seed = 32'h28;
  logic [31:0] v;
  int          err_total = 0;
  int          tests_run = 0;
  int          n;
  wire         pin_w = oe_n ? pin_lvl : pin_o;

  // Clocks: 100 MHz main, slow RTC off the sampling edge
  always #5 clock_i = ~clock_i;
  always #80 rtc_clk_i = ~rtc_clk_i;

  tcu_cpu_model cpu
  (
    .clock_i(clock_i), .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_o(wr_i), .rd_o(rd_i)
  );

  tcu_top dut
  (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .low_power_i(low_power_i), .rtc_clk_i(rtc_clk_i),
    .timer_ext_pin_i(pin_w), .timer_ext_pin_o(pin_o),
    .timer_ext_pin_oe_n_o(oe_n), .underflow_irq_o(unf_irq),
    .capture_irq_o(cap_irq)
  );

  task automatic finish_test;
  begin
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
  begin
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask

  // Read results are matched against the oldest note
  always @(posedge clock_i)
  begin
    if (rd_seen)
      check(rdata_o, exp_q.pop_front());
    rd_seen <= rd_i;
  end

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
  begin
    exp_q.push_back(e);
    cpu.rd(a);
  end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // One pin edge against a capture setting, then flag cleared
  task automatic capt(input logic [1:0] c, input logic [1:0] e,
                      input logic lvl, input logic [31:0] val);
    logic [31:0] cfg;
    logic        hit;
  begin
    cfg = {24'h0, c, 1'b0, e, 3'h0};
    hit = c[1] && (e[1] || e[0] != lvl);
    cpu.wr(8'h24, val);
    cpu.wr(8'h28, cfg);
    @(posedge clock_i);
    pin_lvl <= lvl;
    repeat (4) @(posedge clock_i);
    if (hit)
      cap_exp = val;
    rd(8'h28, cfg | {22'h0, hit, 9'h0});
    rd(8'h2C, cap_exp);
    check({31'h0, cap_irq}, {31'h0, hit & c[0]});
    cpu.wr(8'h28, cfg);
  end
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h28, 32'h0);
    rd(8'h0C, 32'hFFFFFFFF);
    rd(8'h30, 32'h0);
    cpu.wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'h1);
    cpu.wr(8'h10, 32'hFFFFFFFD);
    rd(8'h10, 32'h3D);
    cpu.wr(8'h28, 32'hFD);
    rd(8'h28, 32'hFD);
    cpu.wr(8'h04, 32'hFF);
    rd(8'h04, 32'h7);
    cpu.wr(8'h04, 32'h0);
    check({31'h0, oe_n}, 32'h0);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h28, 32'h0);
    check({31'h0, oe_n}, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      v = {26'h0, seed[5:3], seed[2] & ~seed[1], seed[1:0]};
      cpu.wr(8'h1C, v | 32'hFFFF0000);
      rd(8'h1C, v);
    end
    cpu.wr(8'h08, 32'h3);
    cpu.wr(8'h0C, 32'h2);
    cpu.wr(8'h10, 32'h20);
    cpu.wr(8'h18, 32'h0);
    cpu.wr(8'h1C, 32'h0);
    cpu.wr(8'h04, 32'h3);
    n = 0;
    while (unf_irq[0] !== 1'b1 && n < 200)
    begin
      @(posedge clock_i);
      n++;
    end
    if (n == 200)
    begin
      err_total++;
      finish_test();
    end
    cpu.wr(8'h04, 32'h0);
    rd(8'h10, 32'h120);
    rd(8'h1C, 32'h100);
    check({29'h0, unf_irq}, 32'h1);
    cpu.wr(8'h10, 32'h120);
    rd(8'h10, 32'h120);
    cpu.wr(8'h10, 32'h20);
    rd(8'h10, 32'h20);
    check({29'h0, unf_irq}, 32'h0);
    cpu.wr(8'h00, 32'h1);
    cpu.wr(8'h10, 32'h0);
    cpu.wr(8'h1C, 32'h5);
    cpu.wr(8'h28, 32'h4);
    cpu.wr(8'h04, 32'h7);
    low_power_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    low_power_i <= 1'b0;
    rd(8'h04, 32'h4);
    rd(8'h1C, 32'h5);
    rd(8'h00, 32'h1);
    cpu.wr(8'h04, 32'h0);
    cpu.wr(8'h00, 32'h0);
    for (int c = 0; c < 4; c++)
      if (c != 1)
        for (int e = 0; e < 3; e++)
        begin
          capt(c[1:0], e[1:0], 1'b1, 32'h100 + 32'(c * 16 + e));
          capt(c[1:0], e[1:0], 1'b0, 32'h200 + 32'(c * 16 + e));
        end
    repeat (3) @(posedge clock_i);
    finish_test();
  end
endmodule // testbench
